/* hw/dsom_pkg.sv */
/*
 * Constants for the drive status output mapper.
 * Assumes a single system clock domain and a synchronous reset.
 */
package dsom_pkg;

   // -----------------------------------------------------------------
   // Sizes
   // -----------------------------------------------------------------
   localparam int DSOM_CHANNELS = 4;
   localparam int DSOM_CODE_W   = 8;
   localparam int DSOM_SPEED_W  = 16;
   localparam int DSOM_TORQ_W   = 16;

   // -----------------------------------------------------------------
   // Output function codes
   // -----------------------------------------------------------------
   localparam logic [7:0] DSOM_FN_OFF        = 8'h80;
   localparam logic [7:0] DSOM_FN_READY      = 8'h81;
   localparam logic [7:0] DSOM_FN_FAULT      = 8'h82;
   localparam logic [7:0] DSOM_FN_WARNING    = 8'h83;
   localparam logic [7:0] DSOM_FN_ROTATION   = 8'h84;
   localparam logic [7:0] DSOM_FN_ZERO_SPEED = 8'h85;
   localparam logic [7:0] DSOM_FN_POS_DONE   = 8'h86;
   localparam logic [7:0] DSOM_FN_POS_NEAR   = 8'h87;
   localparam logic [7:0] DSOM_FN_SPD_CONS   = 8'h88;
   localparam logic [7:0] DSOM_FN_SPD_NEAR   = 8'h89;
   localparam logic [7:0] DSOM_FN_TORQ_ARR   = 8'h8A;

   // Output pins are driven low while in reset, whatever each channel's polarity
   localparam logic DSOM_RST_LEVEL = 1'b0;

endpackage : dsom_pkg

/* hw/dsom_status_cmp.sv */
/*
 * Threshold comparators that turn signed speed and torque into the
 * status flags the output mapper selects from.
 * Assumes signed two's complement inputs on the system clock.
 */
`timescale 1ns/1ps
module dsom_status_cmp
   import dsom_pkg::*;
(
   input  wire logic                           sys_clk,
   input  wire logic                           rst,
   input  wire logic signed [DSOM_SPEED_W-1:0] motor_speed,
   input  wire logic signed [DSOM_SPEED_W-1:0] filtered_speed,
   input  wire logic signed [DSOM_TORQ_W-1:0]  torque_instruction,
   input  wire logic [DSOM_SPEED_W-1:0]        rotation_detect_threshold,
   input  wire logic [DSOM_SPEED_W-1:0]        speed_approach_threshold,
   input  wire logic [DSOM_TORQ_W-1:0]         torque_setting,
   output logic                                rotation_flag,
   output logic                                speed_approach_flag,
   output logic                                torque_arrival_flag
);

   // Magnitude; the most negative value saturates rather than wrapping
   function automatic logic [DSOM_SPEED_W-1:0] dsom_abs(
      input logic signed [DSOM_SPEED_W-1:0] v);
      logic [DSOM_SPEED_W-1:0] n;
      n = DSOM_SPEED_W'(-v);
      if (!v[DSOM_SPEED_W-1]) begin
         dsom_abs = v;
      end else if (n[DSOM_SPEED_W-1]) begin
         dsom_abs = {1'b0, {(DSOM_SPEED_W-1){1'b1}}};
      end else begin
         dsom_abs = n;
      end
   endfunction : dsom_abs

   wire logic [DSOM_SPEED_W-1:0] speed_mag = dsom_abs(motor_speed);
   wire logic [DSOM_SPEED_W-1:0] filt_mag  = dsom_abs(filtered_speed);
   wire logic [DSOM_TORQ_W-1:0]  torq_mag  = dsom_abs(torque_instruction);

   wire logic next_rotation = speed_mag > rotation_detect_threshold;
   wire logic next_approach = filt_mag < speed_approach_threshold;
   wire logic next_torque   = torq_mag >= torque_setting;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rotation_flag       <= 1'b0;
         speed_approach_flag <= 1'b0;
         torque_arrival_flag <= 1'b0;
      end else begin
         rotation_flag       <= next_rotation;
         speed_approach_flag <= next_approach;
         torque_arrival_flag <= next_torque;
      end
   end

endmodule : dsom_status_cmp

/* hw/dsom_mapper.sv */
/*
 * Drive status output mapper: each digital output channel carries the
 * status condition selected by its function code.
 * Assumes status inputs and codes are synchronous to sys_clk; the
 * host reads the output lines directly.
 */
`timescale 1ns/1ps
module dsom_mapper
   import dsom_pkg::*;
(
   input  wire logic                           sys_clk,
   input  wire logic                           rst,
   input  wire logic [DSOM_CODE_W-1:0]         channel_code [DSOM_CHANNELS],
   input  wire logic [DSOM_CHANNELS-1:0]       channel_active_low,
   input  wire logic                           drive_ready,
   input  wire logic                           fault_active,
   input  wire logic                           warning_active,
   input  wire logic                           motor_stopped,
   input  wire logic                           positioning_done,
   input  wire logic                           positioning_near,
   input  wire logic                           speed_mode,
   input  wire logic                           speed_consistent_flag,
   input  wire logic signed [DSOM_SPEED_W-1:0] motor_speed,
   input  wire logic signed [DSOM_SPEED_W-1:0] filtered_speed,
   input  wire logic signed [DSOM_TORQ_W-1:0]  torque_instruction,
   input  wire logic [DSOM_SPEED_W-1:0]        rotation_detect_threshold,
   input  wire logic [DSOM_SPEED_W-1:0]        speed_approach_threshold,
   input  wire logic [DSOM_TORQ_W-1:0]         torque_setting,
   output logic [DSOM_CHANNELS-1:0]            channel_out,
   output logic [DSOM_CHANNELS-1:0]            channel_valid
);

   // -----------------------------------------------------------------
   // Derived status flags
   // -----------------------------------------------------------------
   logic rotation_flag;
   logic speed_approach_flag;
   logic torque_arrival_flag;

   dsom_status_cmp u_cmp (
      .sys_clk                   (sys_clk),
      .rst                       (rst),
      .motor_speed               (motor_speed),
      .filtered_speed            (filtered_speed),
      .torque_instruction        (torque_instruction),
      .rotation_detect_threshold (rotation_detect_threshold),
      .speed_approach_threshold  (speed_approach_threshold),
      .torque_setting            (torque_setting),
      .rotation_flag             (rotation_flag),
      .speed_approach_flag       (speed_approach_flag),
      .torque_arrival_flag       (torque_arrival_flag)
   );

   // Consistency only means something in speed mode
   wire logic spd_cons = speed_mode & speed_consistent_flag;

   // -----------------------------------------------------------------
   // Code decode
   // -----------------------------------------------------------------
   function automatic logic dsom_select(input logic [DSOM_CODE_W-1:0] c,
                                        input logic [9:0] st);
      case (c)
         DSOM_FN_OFF:        dsom_select = 1'b0;
         DSOM_FN_READY:      dsom_select = st[0];
         DSOM_FN_FAULT:      dsom_select = st[1];
         DSOM_FN_WARNING:    dsom_select = st[2];
         DSOM_FN_ROTATION:   dsom_select = st[3];
         DSOM_FN_ZERO_SPEED: dsom_select = st[4];
         DSOM_FN_POS_DONE:   dsom_select = st[5];
         DSOM_FN_POS_NEAR:   dsom_select = st[6];
         DSOM_FN_SPD_CONS:   dsom_select = st[7];
         DSOM_FN_SPD_NEAR:   dsom_select = st[8];
         DSOM_FN_TORQ_ARR:   dsom_select = st[9];
         // Codes not handled here read as invalid, like the unused code
         default:            dsom_select = 1'b0;
      endcase
   endfunction : dsom_select

   wire logic [9:0] status_vec = {torque_arrival_flag,
      speed_approach_flag, spd_cons, positioning_near, positioning_done,
      motor_stopped, rotation_flag, warning_active, fault_active,
      drive_ready};

   logic [DSOM_CHANNELS-1:0] next_channel_valid;
   logic [DSOM_CHANNELS-1:0] next_channel_out;

   always_comb begin
      for (int i = 0; i < DSOM_CHANNELS; i++) begin
         next_channel_valid[i] = dsom_select(channel_code[i], status_vec);
         // Pin level follows polarity so a wire break reads as invalid
         next_channel_out[i] = next_channel_valid[i] ^ channel_active_low[i];
      end
   end

   // -----------------------------------------------------------------
   // Output registers
   // -----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         channel_valid <= '0;
         channel_out   <= {DSOM_CHANNELS{DSOM_RST_LEVEL}};
      end else begin
         channel_valid <= next_channel_valid;
         channel_out   <= next_channel_out;
      end
   end

endmodule : dsom_mapper

/* bench/dsom_host_model.sv */
/* Host controller model reading the mapper's output pins.
   Assumes the pins are registered on sys_clk. */
`timescale 1ns/1ps
module dsom_host_model
   import dsom_pkg::*;
(
   input  wire logic                     sys_clk,
   input  wire logic [DSOM_CHANNELS-1:0] pins,
   output logic      [DSOM_CHANNELS-1:0] seen
);
   // A real host registers its inputs, so it sees the pins a clock late
   always_ff @(posedge sys_clk) begin
      seen <= pins;
   end
endmodule : dsom_host_model

/* bench/dsom_mapper_checker.sv */
/* Port checker for dsom_mapper; code maps watched on channel 0.
   Assumes one clock and bound to the mapper by the statement below. */
`timescale 1ns/1ps
module dsom_mapper_checker
   import dsom_pkg::*;
(
   input wire logic               sys_clk,
   input wire logic               rst,
   input wire logic [7:0]         channel_code [DSOM_CHANNELS],
   input wire logic [3:0]         channel_active_low,
   input wire logic               drive_ready,
   input wire logic               fault_active,
   input wire logic               warning_active,
   input wire logic               speed_mode,
   input wire logic               speed_consistent_flag,
   input wire logic signed [15:0] motor_speed,
   input wire logic [15:0]        rotation_detect_threshold,
   input wire logic [3:0]         channel_out,
   input wire logic [3:0]         channel_valid
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Most negative speed saturates, as the comparator does
   logic [15:0] spd_mag;
   assign spd_mag = (motor_speed == 16'sh8000) ? 16'h7FFF :
      (motor_speed < 0) ? 16'(-motor_speed) : 16'(motor_speed);
   sequence s_rot_held;
      (!rst && channel_code[0] == DSOM_FN_ROTATION) [*2];
   endsequence
   a_reset_idle: assert property (disable iff (1'b0) rst
      |=> channel_valid == 4'h0 && channel_out == 4'h0) else $error("reset");
   a_pin_polarity: assert property (!$past(rst)
      |-> channel_out == (channel_valid ^ $past(channel_active_low)))
      else $error("pin polarity");
   a_off_never: assert property (channel_code[0] == DSOM_FN_OFF
      |=> !channel_valid[0]) else $error("off code valid");
   // Reset released on the sampling edge is not seen by disable iff
   a_ready_map: assert property (channel_code[0] == DSOM_FN_READY
      && !rst |=> channel_valid[0] == $past(drive_ready)) else $error("ready");
   a_fault_map: assert property (channel_code[0] == DSOM_FN_FAULT
      && !rst |=> channel_valid[0] == $past(fault_active))
      else $error("fault");
   a_warn_map: assert property (channel_code[0] == DSOM_FN_WARNING
      && !rst |=> channel_valid[0] == $past(warning_active))
      else $error("warning");
   a_rot_detect: assert property (s_rot_held |=> channel_valid[0] ==
      $past(spd_mag > rotation_detect_threshold, 2)) else $error("rotation");
   a_cons_map: assert property (channel_code[0] == DSOM_FN_SPD_CONS
      && !rst |=> channel_valid[0] ==
      $past(speed_mode && speed_consistent_flag)) else $error("consistent");
endmodule : dsom_mapper_checker
bind dsom_mapper dsom_mapper_checker chk (.sys_clk, .rst, .channel_code,
   .channel_active_low, .drive_ready, .fault_active, .warning_active,
   .speed_mode, .speed_consistent_flag, .motor_speed,
   .rotation_detect_threshold, .channel_out, .channel_valid);

/* bench/drive_status_output_mapper_test.sv */
/* Bench for dsom_mapper: reset, every code, speed and torque limits.
   Assumes the checker binds itself and the host model reads the pins. */
`timescale 1ns/1ps
module drive_status_output_mapper_test;
   import dsom_pkg::*;
   logic               sys_clk = 1'b0;
   logic               rst = 1'b1;
   logic [7:0]         code [DSOM_CHANNELS];
   logic [7:0]         stat = 8'h00;
   logic               smode = 1'b0;
   logic signed [15:0] spd = '0, fspd = '0, trq = '0;
   // Distinct limits so a swapped threshold wire shows up
   logic [15:0]        thr_rot = 16'h0064, thr_near = 16'h00C8;
   logic [15:0]        thr_torq = 16'h012C;
   logic [3:0]         pol = 4'h5, valid, pins, seen;
   int                 n_errors = 0, checked = 0, cycles = 0;
   dsom_mapper uut (.sys_clk(sys_clk), .rst(rst), .channel_code(code),
      .channel_active_low(pol), .drive_ready(stat[0]), .fault_active(stat[1]),
      .warning_active(stat[2]), .motor_stopped(stat[4]),
      .positioning_done(stat[5]), .positioning_near(stat[6]),
      .speed_mode(smode), .speed_consistent_flag(stat[7]),
      .motor_speed(spd), .filtered_speed(fspd), .torque_instruction(trq),
      .rotation_detect_threshold(thr_rot),
      .speed_approach_threshold(thr_near),
      .torque_setting(thr_torq), .channel_out(pins), .channel_valid(valid));
   dsom_host_model host (.sys_clk(sys_clk), .pins(pins), .seen(seen));
   always #2.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         n_errors++;
         tally_and_finish();
      end
   end
   task automatic cmp(input logic [3:0] got, input logic [3:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   // Same code on all channels, so both pin polarities are seen at once
   task automatic apply(input logic [7:0] c, input logic [7:0] st,
         input logic sm, input logic signed [15:0] s, f, t, input logic e);
      @(posedge sys_clk);
      code <= '{default: c};
      stat <= st;
      smode <= sm;
      spd <= s;
      fspd <= f;
      trq <= t;
      repeat (4) @(posedge sys_clk);
      #1;
      cmp(valid, {4{e}});
      cmp(seen, {4{e}} ^ pol);
   endtask : apply
   task automatic t_reset();
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      #1;
      cmp(valid, 4'h0);
      cmp(pins, 4'h0);
   endtask : t_reset
   task automatic t_discrete();
      for (int c = 0; c < 9; c++) begin
         for (int j = 0; j < 8; j++) begin
            apply(8'h80 + 8'(c), 8'h01 << j, 1'b1, '0, 16'sh7FFF, '0,
               c == j + 1 && c != 4);
         end
      end
      apply(DSOM_FN_SPD_CONS, 8'hFF, 1'b0, '0, '0, '0, 1'b0);
      apply(DSOM_FN_OFF, 8'hFF, 1'b1, 16'sh7FFF, '0, 16'sh7FFF, 1'b0);
      apply(8'h8B, 8'hFF, 1'b1, 16'sh7FFF, '0, 16'sh7FFF, 1'b0);
   endtask : t_discrete
   task automatic t_limits();
      apply(DSOM_FN_ROTATION, '0, 1'b0, 16'sd100, '0, '0, 1'b0);
      apply(DSOM_FN_ROTATION, '0, 1'b0, -16'sd101, '0, '0, 1'b1);
      apply(DSOM_FN_ROTATION, '0, 1'b0, 16'sh8000, '0, '0, 1'b1);
      apply(DSOM_FN_SPD_NEAR, '0, 1'b0, '0, 16'sd199, '0, 1'b1);
      apply(DSOM_FN_SPD_NEAR, '0, 1'b0, '0, -16'sd200, '0, 1'b0);
      apply(DSOM_FN_TORQ_ARR, '0, 1'b0, '0, '0, -16'sd300, 1'b1);
      apply(DSOM_FN_TORQ_ARR, '0, 1'b0, '0, '0, 16'sd299, 1'b0);
   endtask : t_limits
   // Reset taken while a channel shows valid, then recovery
   task automatic t_mid_reset();
      apply(DSOM_FN_READY, 8'h01, 1'b0, '0, '0, '0, 1'b1);
      @(posedge sys_clk);
      rst <= 1'b1;
      @(posedge sys_clk);
      rst <= 1'b0;
      #1;
      cmp(valid, 4'h0);
      cmp(pins, 4'h0);
      repeat (2) @(posedge sys_clk);
      #1;
      cmp(valid, 4'hF);
      cmp(seen, 4'hF ^ pol);
   endtask : t_mid_reset
   task automatic tally_and_finish();
      $display("Comparisons: %0d, mismatches: %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      code = '{default: DSOM_FN_OFF};
      t_reset();
      t_discrete();
      t_limits();
      t_mid_reset();
      tally_and_finish();
   end
endmodule : drive_status_output_mapper_test
